// *** logic/ocp_pkg.sv ***
package ocp_pkg;
  // Fault counter width and the count that declares a fault.
  localparam int CNT_W = 3;
  localparam logic [2:0] FAULT_LIMIT = 3'h7;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] CNT_ONE = 3'h1;
  // Number of soft-start cycles run in hiccup mode.
  localparam logic [2:0] HICCUP_CYCLES = 3'h7;
  // Blanking timeout in ns and its cycle count at 200 MHz (longest time, rounded down).
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BLANK_TIMEOUT_NS = 200;
  localparam int BLANK_CYCLES_I = (BLANK_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [7:0] BLANK_CYCLES = BLANK_CYCLES_I[7:0];
  localparam logic [7:0] BLANK_ZERO = 8'h00;

  // Operating states, one-hot.
  typedef enum logic [3:0] {
    ST_SHUTDOWN = 4'h1,
    ST_SOFTSTART = 4'h2,
    ST_RUN = 4'h4,
    ST_HICCUP = 4'h8
  } mode_t;

  // Synchronised analog comparator results.
  typedef struct packed {
    logic shutdown_req;
    logic switch_high;
    logic threshold_low;
    logic overcurrent;
    logic ss_done;
  } sense_t;

  // Gate drive outputs.
  typedef struct packed {
    logic high_side_drive;
    logic low_side_drive;
  } drive_t;
endpackage

// *** logic/pin_sync.sv ***
module pin_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous pins and their filtered copy.
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_synced;

  // Elaboration check: a chain without bits has nothing to carry.
  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync needs WIDTH of one or more.");
  end

  // A change is accepted only when stages two and three agree, which rejects one-cycle glitches.
  always_comb begin
    next_synced = synced;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2[i] == s3[i]) begin
        next_synced[i] = s2[i];
      end
    end
  end

  // Three-stage chain; the first stage feeds only the second.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      synced <= '0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      synced <= next_synced;
    end
  end
endmodule

// *** logic/overcurrent_hiccup_protection.sv ***
// Behaviour
// - Overcurrent is only evaluated while the high-side gate is driven on.
// - An overcurrent trip ends the high-side pulse immediately.
// - After a trip high-side stays off until the next switching cycle starts.
// - Blanking starts on the same edge as high-side turn-on, pulling the threshold node low.
// - Blanking ends when the switch node rises near the main supply.
// - Blanking also ends when an internal timeout expires.
// - Comparator output is ignored while blanking is active.
// - A threshold node far below supply disables detection entirely.
// - Fault counter counts up per tripped cycle, down per clean cycle.
// - Counter reaching seven declares a fault and enters hiccup mode.
// - Hiccup runs seven soft-start cycles with modulator and both drives off.
// - During hiccup the counter decrements once per completed soft-start cycle.
// - At zero count the modulator is re-enabled and a normal restart follows.
// - Soft-start pin below 250 mV shuts down with both drives low.
// - In soft-start low-side stays off until the first high-side pulse.
module overcurrent_hiccup_protection (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Switching-cycle timing and modulator request, same clock.
  input wire logic cycle_start,
  input wire logic pwm_request,
  // Analog comparator pins, asynchronous.
  input wire logic soft_start_below_limit,
  input wire logic switch_node_high,
  input wire logic threshold_node_low,
  input wire logic overcurrent_cmp,
  input wire logic soft_start_cycle_done,
  // Gate drives and status.
  output logic high_side_drive,
  output logic low_side_drive,
  output logic overcurrent_threshold_node_pulldown,
  output logic pwm_enable,
  output logic fault_active,
  output logic [2:0] fault_count
);
  ocp_pkg::sense_t sense;
  ocp_pkg::sense_t sense_prev;
  ocp_pkg::mode_t mode;
  ocp_pkg::mode_t next_mode;
  logic [2:0] next_fault_count;
  logic [2:0] hiccup_left;
  logic [2:0] next_hiccup_left;
  logic [7:0] blank_cnt;
  logic [7:0] next_blank_cnt;
  logic blanking;
  logic next_blanking;
  logic tripped;
  logic next_tripped;
  logic cycle_tripped;
  logic next_cycle_tripped;
  logic first_pulse_seen;
  logic next_first_pulse_seen;
  logic next_high_side_drive;
  logic next_low_side_drive;
  logic next_pulldown;
  logic trip;
  logic ss_done_pulse;
  logic next_fault_active;
  logic next_pwm_enable;

  // Saturating step of the fault counter.
  function automatic logic [2:0] count_step(input logic [2:0] v, input logic up);
    if (up) begin
      count_step = (v == ocp_pkg::FAULT_LIMIT) ? v : v + ocp_pkg::CNT_ONE;
    end else begin
      count_step = (v == ocp_pkg::CNT_ZERO) ? v : v - ocp_pkg::CNT_ONE;
    end
  endfunction

  pin_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pins({soft_start_below_limit, switch_node_high, threshold_node_low, overcurrent_cmp, soft_start_cycle_done}),
    .synced(sense)
  );

  // A trip counts only with the gate on, blanking over, and the threshold node in range.
  assign trip = high_side_drive && !blanking && !sense.threshold_low && sense.overcurrent;
  assign ss_done_pulse = sense.ss_done && !sense_prev.ss_done;

  // Operating mode and fault counter; shutdown overrides everything else.
  always_comb begin
    next_mode = mode;
    next_fault_count = fault_count;
    next_hiccup_left = hiccup_left;
    if (sense.shutdown_req) begin
      next_mode = ocp_pkg::ST_SHUTDOWN;
    end else begin
      case (mode)
        ocp_pkg::ST_SHUTDOWN: begin
          next_mode = ocp_pkg::ST_SOFTSTART;
        end
        ocp_pkg::ST_SOFTSTART, ocp_pkg::ST_RUN: begin
          if (cycle_start) begin
            next_fault_count = count_step(fault_count, cycle_tripped || trip);
            if (first_pulse_seen) begin
              next_mode = ocp_pkg::ST_RUN;
            end
          end
          if (next_fault_count == ocp_pkg::FAULT_LIMIT) begin
            next_mode = ocp_pkg::ST_HICCUP;
            next_hiccup_left = ocp_pkg::HICCUP_CYCLES;
          end
        end
        ocp_pkg::ST_HICCUP: begin
          if (ss_done_pulse) begin
            next_fault_count = count_step(fault_count, 1'b0);
            next_hiccup_left = count_step(hiccup_left, 1'b0);
          end
          if (next_fault_count == ocp_pkg::CNT_ZERO && next_hiccup_left == ocp_pkg::CNT_ZERO) begin
            next_mode = ocp_pkg::ST_SOFTSTART;
          end
        end
        default: begin
          next_mode = ocp_pkg::ST_SHUTDOWN;
        end
      endcase
    end
    // Status flags follow the mode being entered, so they change on the same edge as the mode.
    next_fault_active = (next_mode == ocp_pkg::ST_HICCUP);
    next_pwm_enable = (next_mode == ocp_pkg::ST_SOFTSTART) || (next_mode == ocp_pkg::ST_RUN);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= ocp_pkg::ST_SHUTDOWN;
      fault_count <= ocp_pkg::CNT_ZERO;
      hiccup_left <= ocp_pkg::CNT_ZERO;
      sense_prev <= '0;
      fault_active <= 1'b0;
      pwm_enable <= 1'b0;
    end else begin
      mode <= next_mode;
      fault_count <= next_fault_count;
      hiccup_left <= next_hiccup_left;
      sense_prev <= sense;
      fault_active <= next_fault_active;
      pwm_enable <= next_pwm_enable;
    end
  end

  // Per-cycle pulse control: blanking, trip latch and gate drives.
  always_comb begin
    next_blanking = blanking;
    next_blank_cnt = blank_cnt;
    next_tripped = tripped;
    next_cycle_tripped = cycle_tripped;
    next_first_pulse_seen = first_pulse_seen;
    next_high_side_drive = high_side_drive;
    if (cycle_start) begin
      next_tripped = 1'b0;
      next_cycle_tripped = 1'b0;
      next_high_side_drive = 1'b0;
      if (pwm_request) begin
        // Blanking rises on the same edge as the gate, so the trip path is masked from the first on-cycle.
        next_blanking = 1'b1;
        next_blank_cnt = ocp_pkg::BLANK_CYCLES;
        next_high_side_drive = 1'b1;
      end
    end else begin
      if (blanking) begin
        if (sense.switch_high) begin
          next_blanking = 1'b0;
        end else if (blank_cnt == ocp_pkg::BLANK_ZERO) begin
          next_blanking = 1'b0;
        end else begin
          next_blank_cnt = blank_cnt - 8'h01;
        end
      end
      if (trip) begin
        next_tripped = 1'b1;
        next_cycle_tripped = 1'b1;
        next_high_side_drive = 1'b0;
      end else if (!pwm_request || tripped) begin
        next_high_side_drive = 1'b0;
      end
    end
    if (high_side_drive) begin
      next_first_pulse_seen = 1'b1;
    end
    if (next_mode != ocp_pkg::ST_RUN && next_mode != ocp_pkg::ST_SOFTSTART) begin
      // Modulator disabled: no gate activity and the soft-start sequence starts over.
      // The mode being entered is used so that a cycle start on the hiccup edge cannot launch a pulse.
      next_high_side_drive = 1'b0;
      next_blanking = 1'b0;
      next_first_pulse_seen = 1'b0;
    end
    next_pulldown = next_blanking;
    // Low-side waits for the first high-side pulse; both gates are never on together.
    next_low_side_drive = !next_high_side_drive && first_pulse_seen && !high_side_drive
                          && (next_mode == ocp_pkg::ST_RUN || next_mode == ocp_pkg::ST_SOFTSTART);
    if (sense.shutdown_req) begin
      next_low_side_drive = 1'b0;
      next_high_side_drive = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blanking <= 1'b0;
      blank_cnt <= ocp_pkg::BLANK_ZERO;
      tripped <= 1'b0;
      cycle_tripped <= 1'b0;
      first_pulse_seen <= 1'b0;
      high_side_drive <= 1'b0;
      low_side_drive <= 1'b0;
      overcurrent_threshold_node_pulldown <= 1'b0;
    end else begin
      blanking <= next_blanking;
      blank_cnt <= next_blank_cnt;
      tripped <= next_tripped;
      cycle_tripped <= next_cycle_tripped;
      first_pulse_seen <= next_first_pulse_seen;
      high_side_drive <= next_high_side_drive;
      low_side_drive <= next_low_side_drive;
      overcurrent_threshold_node_pulldown <= next_pulldown;
    end
  end
endmodule

// *** tb/ocp_assertions.sv ***
module ocp_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports.
  input wire logic cycle_start,
  input wire logic soft_start_below_limit,
  input wire logic high_side_drive,
  input wire logic low_side_drive,
  input wire logic overcurrent_threshold_node_pulldown,
  input wire logic pwm_enable,
  input wire logic fault_active,
  input wire logic [2:0] fault_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Six cycles of shutdown allow for the pin synchroniser before drives must be off.
  a_shutdown_drives_off: assert property (soft_start_below_limit [*6] |-> !high_side_drive && !low_side_drive)
    else $error("drive on in shutdown");
  a_shutdown_count_held: assert property (soft_start_below_limit [*6] |=> $stable(fault_count))
    else $error("count moved in shutdown");
  a_hiccup_all_off: assert property (fault_active |-> !high_side_drive && !low_side_drive && !pwm_enable)
    else $error("activity in hiccup");
  a_turn_on_blanked: assert property ($rose(high_side_drive) |-> overcurrent_threshold_node_pulldown)
    else $error("turn-on without blanking");
  a_turn_on_at_start: assert property ($rose(high_side_drive) |-> $past(cycle_start))
    else $error("turn-on outside cycle start");
  a_blank_timeout: assert property ($rose(overcurrent_threshold_node_pulldown) |-> ##[1:41] !overcurrent_threshold_node_pulldown)
    else $error("blanking too long");
  a_count_steps_one: assert property (fault_count != $past(fault_count) |-> (fault_count - $past(fault_count)) inside {3'h1, 3'h7})
    else $error("count jumped");
  a_fault_at_seven: assert property ($rose(fault_active) |-> fault_count == 3'h7 || $past(fault_count) == 3'h7)
    else $error("fault below seven");
  // A shutdown may end hiccup early with a count left; only a restart must find zero.
  a_restart_at_zero: assert property ($fell(fault_active) && pwm_enable |-> fault_count == 3'h0)
    else $error("restart with count left");
  a_no_overlap: assert property (!(high_side_drive && low_side_drive))
    else $error("both drives on");
endmodule
bind overcurrent_hiccup_protection ocp_checker ocp_checker_i (.clk(clk), .rst_n(rst_n), .cycle_start(cycle_start),
  .soft_start_below_limit(soft_start_below_limit), .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
  .overcurrent_threshold_node_pulldown(overcurrent_threshold_node_pulldown), .pwm_enable(pwm_enable),
  .fault_active(fault_active), .fault_count(fault_count));

// *** tb/gate_stage_model.sv ***
module gate_stage_model (
  // Clock.
  input wire logic clk,
  // Gate drive and faults set by the bench.
  input wire logic high_side_drive,
  input wire logic short_circuit,
  input wire logic stuck_low,
  // Comparator results toward the block.
  output logic switch_node_high,
  output logic overcurrent_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] delay;
  // The switch node lags turn-on by two cycles of driver delay and falls with the gate.
  always_ff @(posedge clk) begin
    delay <= {delay[0], high_side_drive};
  end
  assign switch_node_high = delay[1] && high_side_drive && !stuck_low;
  // A short only shows while the high-side switch conducts.
  assign overcurrent_cmp = short_circuit && high_side_drive;
endmodule

// *** tb/tb_overcurrent_hiccup_protection.sv ***
module tb_overcurrent_hiccup_protection;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, cycle_start, pwm_request, ss_low, thr_low, ss_done, short_circuit, stuck_low;
  logic switch_high, oc, hs, ls, blank, pwm_en, fault;
  logic e, be, l, bl;
  logic [2:0] count;
  int errors, checks_done, cycles;
  overcurrent_hiccup_protection overcurrent_hiccup_protection_i (.clk(clk), .rst_n(rst_n),
    .cycle_start(cycle_start), .pwm_request(pwm_request), .soft_start_below_limit(ss_low),
    .switch_node_high(switch_high), .threshold_node_low(thr_low), .overcurrent_cmp(oc),
    .soft_start_cycle_done(ss_done), .high_side_drive(hs), .low_side_drive(ls),
    .overcurrent_threshold_node_pulldown(blank), .pwm_enable(pwm_en), .fault_active(fault), .fault_count(count));
  gate_stage_model gate_stage_model_i (.clk(clk), .high_side_drive(hs), .short_circuit(short_circuit),
    .stuck_low(stuck_low), .switch_node_high(switch_high), .overcurrent_cmp(oc));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One switching cycle; samples are taken 1 ns after an edge so its updates have landed.
  // The early sample falls just before blanking ends, when an unblanked trip would already have cut the gate.
  task automatic run_cycle(input int on);
    @(posedge clk);
    cycle_start <= 1'b1;
    pwm_request <= 1'b1;
    @(posedge clk);
    cycle_start <= 1'b0;
    repeat (6) @(posedge clk);
    #1 e = hs;
    be = blank;
    repeat (on) @(posedge clk);
    #1 l = hs;
    bl = blank;
    @(posedge clk);
    pwm_request <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
  endtask
  // The below-limit pin is held high, like a soft-start node that has not charged up yet.
  task automatic t_shutdown();
    ss_low <= 1'b1;
    run_cycle(20);
    check("hs shut", 0, l);
    check("ls shut", 0, ls);
    check("count shut", 0, count);
    @(posedge clk);
    ss_low <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic t_normal();
    run_cycle(30);
    check("hs held", 1, l);
    check("blank early", 1, be);
    check("blank switch", 0, bl);
    check("ls after pulse", 1, ls);
    @(posedge clk);
    stuck_low <= 1'b1;
    run_cycle(30);
    check("blank stuck", 1, bl);
    run_cycle(50);
    check("blank timeout", 0, bl);
    @(posedge clk);
    stuck_low <= 1'b0;
    check("count clean", 0, count);
  endtask
  task automatic t_disabled();
    @(posedge clk);
    thr_low <= 1'b1;
    short_circuit <= 1'b1;
    run_cycle(30);
    check("hs disabled", 1, l);
    @(posedge clk);
    thr_low <= 1'b0;
  endtask
  task automatic t_hiccup();
    for (int i = 0; i < 7; i++) begin
      run_cycle(30);
      check("hs blanked", 1, e);
      check("hs tripped", 0, l);
    end
    check("count six", 6, count);
    check("no fault", 0, fault);
    run_cycle(30);
    check("fault", 1, fault);
    check("pwm off", 0, pwm_en);
    @(posedge clk);
    short_circuit <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      ss_done <= 1'b1;
      repeat (6) @(posedge clk);
      ss_done <= 1'b0;
      repeat (5) @(posedge clk);
      #1 check("hiccup count", 3'(6 - i), count);
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    #1 check("restart", 0, fault);
    check("pwm on", 1, pwm_en);
    check("ls before pulse", 0, ls);
    run_cycle(30);
    check("hs restart", 1, l);
  endtask
  initial begin
    {cycle_start, pwm_request, thr_low, ss_done, short_circuit, stuck_low} = '0;
    ss_low = 1'b0;
    rst_n = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_shutdown();
    t_normal();
    t_disabled();
    t_hiccup();
    summarize();
  end
  // Cuts a hang short; the whole sequence needs well under two thousand cycles.
  initial begin
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles == 8000) begin
        errors++;
        summarize();
      end
    end
  end
endmodule
